/* ras_defs.vh */
/*
 Constants for the I2C register access slave: bus address, special codes,
 byte widths and the size of the write buffer.
 Assumes nothing; included by the design file by its bare name.
*/
`ifndef RAS_DEFS_VH
`define RAS_DEFS_VH

// Own 7-bit address; 8-bit byte forms are D2 (write) and D3 (read)
`define RAS_DEV_ADDR   7'h69
// General call address, never acknowledged
`define RAS_GCALL_ADDR 7'h00
// High-speed master code 0000_1xxx, upper five bits
`define RAS_HS_CODE    5'h01
// Byte and pointer widths
`define RAS_BYTE_W     8
`define RAS_PTR_W      8
// Write buffer shape: one word is {register, data}
`define RAS_WORD_W     16
`define RAS_FIFO_DEPTH 8
`define RAS_FIFO_AW    3
// Last bit index within a byte
`define RAS_LAST_BIT   3'h7

`endif

/* ras_slave.v */
/*
 I2C register access slave and its 8-word write buffer: takes pointer and data
 bytes from a bus master, queues register writes, serves reads from rd_data.
 Assumes: SCL/SDA arrive asynchronously, sampled by ref_clk (50 MHz) running at
 least 8x faster than SCL; rd_data answers rd_addr combinationally or from
 ref_clk flops; the SDA wire is resolved outside from sda_o/sda_oe.
*/
// How it works
// R1 - Master starts every access with write address
// R2 - Acknowledge own address on ninth clock
// R3 - First written byte sets register pointer
// R4 - Acknowledge data, commit at ack rise
// R5 - Sequential writes advance pointer without limit
// R6 - Last sequential byte acknowledged like others
// R7 - Pair mode alternates pointer and data
// R8 - Pair mode commits last data at STOP
// R9 - Read uses repeated START, read address
// R10 - Send selected register MSB first
// R11 - Master acknowledge advances to next register
// R12 - Master NACK ends read, release SDA
// R13 - Master ends transfers with STOP or Sr
// R14 - STOP restores normal filter; Sr keeps it
// R15 - Answer address bytes D2 and D3
// R16 - SCL is never held low
// R17 - General call is not acknowledged
// R18 - Ignore bus after STOP or mismatch
// R19 - Write mode input sampled at START
`timescale 1ns/1ps
`include "ras_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO with valid/ready on both sides
module ras_fifo #(
	parameter W  = `RAS_WORD_W,
	parameter D  = `RAS_FIFO_DEPTH,
	parameter AW = `RAS_FIFO_AW
) (
	input  wire         clk,       // System clock
	input  wire         rst_n,     // Synchronous reset, active low
	input  wire         in_valid,  // Write word offered
	output wire         in_ready,  // Space available
	input  wire [W-1:0] in_data,   // Word to store
	output wire         out_valid, // Word available
	input  wire         out_ready, // Consumer takes word
	output wire [W-1:0] out_data   // Oldest word
);
	reg [W-1:0]  mem [0:D-1];
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW:0]   count_q;
	wire         push;
	wire         pop;

	// Honest flags from the occupancy count
	assign in_ready  = (count_q != D[AW:0]);
	assign out_valid = (count_q != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Storage has no reset; only pointers and count matter
	always @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_q] <= in_data;
		end
	end

	// Pointers wrap naturally since depth is a power of two
	always @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q  <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			if (push & ~pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop & ~push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule // ras_fifo

////////////////////////////////////////////////////////////////////////////////
// Bus engine
module ras_slave (
	input  wire       ref_clk,   // System clock, 50 MHz
	input  wire       nrst,      // Synchronous reset, active low
	input  wire       scl_i,     // Bus clock pin, input only
	input  wire       sda_i,     // Bus data pin level
	output wire       sda_o,     // Bus data drive value, always 0
	output wire       sda_oe,    // High while pulling SDA low
	input  wire       pair_mode, // 1: register-data pairs, 0: sequential
	output wire       filt_hs,   // High-speed input filter selected
	output wire [7:0] rd_addr,   // Register being read
	input  wire [7:0] rd_data,   // Contents of rd_addr
	output wire       wr_valid,  // Register write pending
	input  wire       wr_ready,  // Register space takes the write
	output wire [7:0] wr_addr,   // Register to write
	output wire [7:0] wr_data    // Value to write
);
	localparam [4:0] ST_IDLE = 5'b00001;
	localparam [4:0] ST_RECV = 5'b00010;
	localparam [4:0] ST_ACK  = 5'b00100;
	localparam [4:0] ST_SEND = 5'b01000;
	localparam [4:0] ST_MACK = 5'b10000;

	reg [4:0] state_q;
	reg [2:0] scl_s_q;
	reg [2:0] sda_s_q;
	reg [2:0] bit_cnt_q;
	reg [7:0] shift_q;
	reg [7:0] ptr_q;
	reg       full_q;     // Eight bits received
	reg       is_addr_q;  // Next received byte is the address
	reg       want_ptr_q; // Next received byte is a pointer
	reg       rw_q;       // Current address asked for a read
	reg       pair_q;     // Pair mode latched at START
	reg       ack_data_q; // Acked byte is data
	reg       more_q;     // Master asked for another byte
	reg       hs_q;
	reg       oe_q;
	reg       pend_q;
	reg [7:0] pend_addr_q;
	reg [7:0] pend_data_q;
	reg       push_d;
	reg [15:0] push_word_d;
	wire      scl;
	wire      sda;
	wire      scl_rise;
	wire      scl_fall;
	wire      start_det;
	wire      stop_det;
	wire      fifo_ready;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; stage 0 feeds only stage 1. SCL is only sampled,
	// the block has no way to drive it (see R16)
	always @(posedge ref_clk) begin
		if (!nrst) begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
		end else begin
			scl_s_q <= {scl_s_q[1:0], scl_i};
			sda_s_q <= {sda_s_q[1:0], sda_i};
		end
	end

	// Edges and bus conditions from stages 1 and 2
	assign scl       = scl_s_q[1];
	assign sda       = sda_s_q[1];
	assign scl_rise  = scl & ~scl_s_q[2];
	assign scl_fall  = ~scl & scl_s_q[2];
	assign start_det = scl & scl_s_q[2] & sda_s_q[2] & ~sda;
	assign stop_det  = scl & scl_s_q[2] & ~sda_s_q[2] & sda;

	////////////////////////////////////////////////////////////////////////
	// Buffer pushes: direct commits at ack rise, deferred pair commits
	always @* begin
		push_d      = 1'b0;
		push_word_d = {pend_addr_q, pend_data_q};
		if (state_q == ST_ACK && scl_rise && ack_data_q && !pair_q) begin
			push_d      = 1'b1;                        // see R4
			push_word_d = {ptr_q, shift_q};
		end else if (pend_q && (stop_det || start_det)) begin
			push_d = 1'b1;                             // see R8
		end else if (pend_q && state_q == ST_ACK && scl_rise && !ack_data_q) begin
			push_d = 1'b1;                             // see R7
		end
	end

	ras_fifo #(.W(`RAS_WORD_W), .D(`RAS_FIFO_DEPTH), .AW(`RAS_FIFO_AW)) u_fifo (
		.clk       (ref_clk),
		.rst_n     (nrst),
		.in_valid  (push_d),
		.in_ready  (fifo_ready),
		.in_data   (push_word_d),
		.out_valid (wr_valid),
		.out_ready (wr_ready),
		.out_data  ({wr_addr, wr_data})
	);

	////////////////////////////////////////////////////////////////////////
	// Byte engine
	always @(posedge ref_clk) begin
		if (!nrst) begin
			state_q     <= ST_IDLE;
			bit_cnt_q   <= 3'h0;
			shift_q     <= 8'h00;
			ptr_q       <= 8'h00;
			full_q      <= 1'b0;
			is_addr_q   <= 1'b0;
			want_ptr_q  <= 1'b0;
			rw_q        <= 1'b0;
			pair_q      <= 1'b0;
			ack_data_q  <= 1'b0;
			more_q      <= 1'b0;
			hs_q        <= 1'b0;
			oe_q        <= 1'b0;
			pend_q      <= 1'b0;
			pend_addr_q <= 8'h00;
			pend_data_q <= 8'h00;
		end else if (stop_det) begin
			// Bus freed: normal filters, deaf until START
			state_q <= ST_IDLE;                        // see R18
			hs_q    <= 1'b0;                           // see R14
			oe_q    <= 1'b0;
			pend_q  <= 1'b0;
		end else if (start_det) begin
			// START or Sr; filter mode deliberately left alone
			state_q   <= ST_RECV;
			bit_cnt_q <= 3'h0;
			full_q    <= 1'b0;
			is_addr_q <= 1'b1;
			pair_q    <= pair_mode;                    // see R19
			oe_q      <= 1'b0;
			pend_q    <= 1'b0;
		end else begin
			case (state_q)
			ST_IDLE: begin
				oe_q <= 1'b0;
			end
			ST_RECV: begin
				if (scl_rise) begin
					shift_q   <= {shift_q[6:0], sda};
					bit_cnt_q <= bit_cnt_q + 1'b1;
					full_q    <= (bit_cnt_q == `RAS_LAST_BIT);
				end else if (scl_fall && full_q) begin
					full_q     <= 1'b0;
					ack_data_q <= 1'b0;
					if (is_addr_q) begin
						is_addr_q <= 1'b0;
						if (shift_q[7:1] == `RAS_DEV_ADDR) begin
							// Own address in either direction
							oe_q       <= 1'b1;       // see R2
							rw_q       <= shift_q[0];  // see R15
							want_ptr_q <= ~shift_q[0]; // see R1
							state_q    <= ST_ACK;
						end else if (shift_q[7:3] == `RAS_HS_CODE) begin
							// Master code is never acked; Sr follows
							hs_q    <= 1'b1;
							state_q <= ST_IDLE;
						end else begin
							// Foreign or general call: stay silent
							state_q <= ST_IDLE;       // see R17
						end
					end else if (want_ptr_q) begin
						ptr_q      <= shift_q;         // see R3
						want_ptr_q <= 1'b0;
						oe_q       <= 1'b1;
						state_q    <= ST_ACK;
					end else if (fifo_ready) begin
						// Ack only with room, so the commit never drops
						ack_data_q <= 1'b1;
						want_ptr_q <= pair_q;          // see R7
						oe_q       <= 1'b1;            // see R6
						state_q    <= ST_ACK;
					end else begin
						state_q <= ST_IDLE;
					end
				end
			end
			ST_ACK: begin
				if (scl_rise && ack_data_q) begin
					if (pair_q) begin
						pend_q      <= 1'b1;
						pend_addr_q <= ptr_q;
						pend_data_q <= shift_q;
					end else begin
						ptr_q <= ptr_q + 8'h01;        // see R5
					end
				end else if (scl_rise && pend_q) begin
					pend_q <= 1'b0;
				end else if (scl_fall) begin
					bit_cnt_q <= 3'h0;
					if (rw_q) begin
						// Read address acked: first bit out
						shift_q <= rd_data;            // see R10
						oe_q    <= ~rd_data[7];
						state_q <= ST_SEND;
					end else begin
						oe_q    <= 1'b0;
						state_q <= ST_RECV;
					end
				end
			end
			ST_SEND: begin
				if (scl_fall) begin
					bit_cnt_q <= bit_cnt_q + 1'b1;
					if (bit_cnt_q == `RAS_LAST_BIT) begin
						oe_q    <= 1'b0;
						state_q <= ST_MACK;
					end else begin
						shift_q <= {shift_q[6:0], 1'b0};
						oe_q    <= ~shift_q[6];
					end
				end
			end
			ST_MACK: begin
				if (scl_rise) begin
					more_q <= ~sda;
					if (!sda) begin
						ptr_q <= ptr_q + 8'h01;        // see R11
					end
				end else if (scl_fall) begin
					bit_cnt_q <= 3'h0;
					if (more_q) begin
						shift_q <= rd_data;
						oe_q    <= ~rd_data[7];
						state_q <= ST_SEND;
					end else begin
						// NACK: hands off, wait for P or Sr
						oe_q    <= 1'b0;               // see R12
						state_q <= ST_IDLE;
					end
				end
			end
			default: begin
				state_q <= ST_IDLE;
				oe_q    <= 1'b0;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign sda_o   = 1'b0;
	assign sda_oe  = oe_q;
	assign filt_hs = hs_q;
	assign rd_addr = ptr_q;
endmodule // ras_slave

/* ras_slave_asserts.sv */
/* Port checker for ras_slave.
 Assumes SCL period of 8 ref_clk or more and pins changed 1 ns after an edge. */
`timescale 1ns/1ps
module ras_slave_chk (
	input wire logic	ref_clk,	// Clock
	input wire logic	nrst,	// Reset, low
	input wire logic	scl_i,	// Bus clock
	input wire logic	sda_i,	// Bus data
	input wire logic	sda_o,	// Drive value
	input wire logic	sda_oe,	// Pull low
	input wire logic	pair_mode,	// Write mode
	input wire logic	filt_hs,	// Fast filter
	input wire logic [7:0]	rd_addr,	// Pointer
	input wire logic	wr_valid,	// Word ready
	input wire logic	wr_ready,	// Word taken
	input wire logic [7:0]	wr_addr,	// Word target
	input wire logic [7:0]	wr_data	// Word value
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// Open drain: only ever pulls low
	property p_od; sda_o == 1'b0; endproperty
	a_od: assert property (p_od) else $error("sda_o driven high");
	// Quiet state straight after reset
	property p_rst; $rose(nrst) |-> !sda_oe && !filt_hs && !wr_valid && rd_addr == 8'h00; endproperty
	a_rst: assert property (p_rst) else $error("outputs not idle after reset");
	// Pending word stands until taken
	property p_hold; wr_valid && !wr_ready |=> wr_valid && $stable({wr_addr, wr_data}); endproperty
	a_hold: assert property (p_hold) else $error("write word dropped");
	// Drive changes only while SCL is low
	property p_oe_low; $changed(sda_oe) |-> !scl_i; endproperty
	a_oe_low: assert property (p_oe_low) else $error("sda_oe moved with SCL high");
	property p_oe_hi; $rose(scl_i) |=> $stable(sda_oe)[*4]; endproperty
	a_oe_hi: assert property (p_oe_hi) else $error("sda_oe unstable in high phase");
	// STOP returns the filter to normal speed
	property p_stop; scl_i && $rose(sda_i) |-> ##[1:6] !filt_hs; endproperty
	a_stop: assert property (p_stop) else $error("filter kept after stop");
	// No drive for eight ref_clk cycles after a START
	property p_start; scl_i && $fell(sda_i) |-> !sda_oe [*8]; endproperty
	a_start: assert property (p_start) else $error("drive right after start");
	// Words appear only at a high SCL phase (ack rise, STOP or Sr)
	property p_commit; $rose(wr_valid) |-> $past(scl_i, 2); endproperty
	a_commit: assert property (p_commit) else $error("write word at wrong time");
	c_hs: cover property ($rose(filt_hs));
	c_take: cover property (wr_valid && wr_ready);
	c_pair: cover property (pair_mode && $rose(wr_valid));
endmodule // ras_slave_chk

bind ras_slave ras_slave_chk u_chk (.ref_clk(ref_clk), .nrst(nrst), .scl_i(scl_i),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .pair_mode(pair_mode), .filt_hs(filt_hs),
	.rd_addr(rd_addr), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
	.wr_data(wr_data));

/* ras_master.sv */
/* Bus master model: START, STOP and nine-bit transfers, 160 ns per bit.
 Assumes SDA is wire-ANDed with a pull-up outside; called 1 ns after an edge. */
`timescale 1ns/1ps
module ras_master (
	output logic	scl,	// Bus clock, idles high
	output logic	sda,	// Data drive, 1 releases
	input wire logic	sda_line	// Resolved data wire
);
	// Released bus, clock stands still
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// Late SDA release so a slave ack has ended first
	task automatic start();
		#80 sda = 1'b1;
		#40 scl = 1'b1;
		#80 sda = 1'b0;
		#80 scl = 1'b0;
	endtask
	task automatic stop();
		#80 sda = 1'b0;
		#40 scl = 1'b1;
		#80 sda = 1'b1;
		#80;
	endtask
	// MSB first; tx bit 0 is the ack slot
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			#60 sda = tx[i];
			#20 scl = 1'b1;
			#40 rx[i] = sda_line;
			#40 scl = 1'b0;
		end
	endtask
endmodule // ras_master

/* ras_slave_tb.sv */
/* Self-checking bench for ras_slave with a bus master model and a register space.
 Assumes the checker is bound to the design elsewhere. */
`timescale 1ns/1ps
module ras_slave_tb;
	logic	ref_clk, nrst, pair_mode, wr_ready, hold_off;
	wire logic	scl, m_sda, sda_o, sda_oe, filt_hs, wr_valid;
	wire logic [7:0]	rd_addr, wr_addr, wr_data;
	logic [7:0]	mem [256];
	logic [15:0]	expq [$];
	logic [8:0]	rx;
	logic [7:0]	a, d;
	integer	seed, fail_count, checks_done;
	// Pull-up wire-AND of both drivers
	wire logic	sda_line = m_sda & ~sda_oe;
	wire logic [7:0]	rd_data = mem[rd_addr];

	ras_master u_m (.scl(scl), .sda(m_sda), .sda_line(sda_line));
	ras_slave DUT (.ref_clk(ref_clk), .nrst(nrst), .scl_i(scl), .sda_i(sda_line),
		.sda_o(sda_o), .sda_oe(sda_oe), .pair_mode(pair_mode), .filt_hs(filt_hs),
		.rd_addr(rd_addr), .rd_data(rd_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
		.wr_addr(wr_addr), .wr_data(wr_data));

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// Register space stalls at random so the buffer is exercised
	always @(posedge ref_clk) begin
		if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
			chk({wr_addr, wr_data}, expq.pop_front());
			mem[wr_addr] = wr_data;
		end
		wr_ready <= #1 !hold_off && ($random(seed) % 2 != 0);
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic send(input logic [7:0] b, input logic ack);
		logic [8:0] r;
		u_m.xfer({b, 1'b1}, r);
		chk({15'h0, r[0]}, {15'h0, ~ack});
	endtask
	task automatic drain();
		for (int n = 0; n < 400 && expq.size() != 0; n++) @(posedge ref_clk);
		#1;
		chk(16'(expq.size()), 16'h0000);
	endtask
	// Buffer word expected for the k-th data byte of a sequential write
	function automatic logic [15:0] seq_word(input logic [7:0] b, int k, logic [7:0] v);
		return {b + 8'(k), v};
	endfunction
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		#500000;
		fail_count++;
		give_verdict();
	end

	initial begin
		seed = 87303;
		fail_count = 0;
		checks_done = 0;
		nrst = 1'b0;
		pair_mode = 1'b0;
		wr_ready = 1'b0;
		hold_off = 1'b0;
		foreach (mem[i]) mem[i] = $random(seed);
		cyc(10);
		nrst = 1'b1;
		cyc(3);
		// Foreign address, later bytes, general call: all ignored
		u_m.start();
		send(8'hAA, 1'b0);
		send(8'h12, 1'b0);
		u_m.start();
		send(8'h00, 1'b0);
		u_m.stop();
		// Sequential write crossing the top of the pointer range
		u_m.start();
		send(8'hD2, 1'b1);
		send(8'hFE, 1'b1);
		for (int i = 0; i < 3; i++) begin
			d = $random(seed);
			expq.push_back(seq_word(8'hFE, i, d));
			send(d, 1'b1);
		end
		u_m.stop();
		drain();
		chk({8'h00, rd_addr}, 16'h0001);
		// Pairs in random order; the last waits for STOP
		pair_mode = 1'b1;
		u_m.start();
		send(8'hD2, 1'b1);
		// Mode input flips mid-transfer; the latched mode must hold
		pair_mode = 1'b0;
		repeat (3) begin
			a = $random(seed);
			d = $random(seed);
			expq.push_back({a, d});
			send(a, 1'b1);
			send(d, 1'b1);
		end
		cyc(100);
		chk(16'(expq.size()), 16'h0001);
		u_m.stop();
		drain();
		pair_mode = 1'b0;
		// Three sequential reads, master refuses the last
		a = $random(seed);
		u_m.start();
		send(8'hD2, 1'b1);
		send(a, 1'b1);
		u_m.start();
		send(8'hD3, 1'b1);
		for (int i = 0; i < 3; i++) begin
			u_m.xfer({8'hFF, i == 2}, rx);
			chk({8'h00, rx[8:1]}, {8'h00, mem[a + 8'(i)]});
		end
		cyc(4);
		chk({15'h0, sda_oe}, 16'h0000);
		u_m.stop();
		// Fast filter: kept over Sr, cleared by STOP
		u_m.start();
		send(8'h08, 1'b0);
		u_m.start();
		chk({15'h0, filt_hs}, 16'h0001);
		send(8'hD2, 1'b1);
		u_m.stop();
		cyc(6);
		chk({15'h0, filt_hs}, 16'h0000);
		// Stalled register space: buffer fills, ninth byte refused
		hold_off = 1'b1;
		u_m.start();
		send(8'hD2, 1'b1);
		send(8'h40, 1'b1);
		for (int i = 0; i < 8; i++) begin
			d = $random(seed);
			expq.push_back(seq_word(8'h40, i, d));
			send(d, 1'b1);
		end
		send(8'h5A, 1'b0);
		u_m.stop();
		hold_off = 1'b0;
		drain();
		give_verdict();
	end
endmodule // ras_slave_tb
